// *** rtl/ouvf_responder.sv ***
/*
 * Output undervoltage fault responder: action register, ride-through
 * and restart timing, output enable and latched fault state.
 * Assumes the fault flag arrives from another domain and the register
 * port is driven on core_clk.
 */
`include "ouvf_regs.svh"
`default_nettype none
module ouvf_responder #(
	parameter int MS_CYCLES = `OUVF_MS_CYCLES
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Fault sense
	input  wire logic       uv_fault,
	// Register port
	input  wire logic [7:0] cfg_addr,
	input  wire logic       cfg_wr_en,
	input  wire logic [7:0] cfg_wdata,
	input  wire logic       cfg_rd_en,
	output logic      [7:0] cfg_rdata,
	// Status
	output logic            out_enable,
	output logic            fault_latched,
	output logic      [2:0] retries_used
);
	logic        fault_meta;
	logic        fault_s;
	logic [7:0]  action_reg;
	logic [7:0]  rdata_reg;
	logic [15:0] pre_reg;
	logic [11:0] ms_reg;
	logic [2:0]  retry_reg;
	logic        out_en_reg;
	logic        latched_reg;
	logic [1:0]  resp;
	logic [2:0]  retry_lim;
	logic [2:0]  dcode;
	logic [11:0] target_ms;
	logic        timer_done;
	logic        seq_start;
	logic        out_of_retries;
	ouvf_pkg::ouvf_state_e state_reg;
	ouvf_pkg::ouvf_state_e state_next;

	assign resp      = action_reg[`OUVF_RESP_MSB:`OUVF_RESP_LSB];
	assign retry_lim = action_reg[`OUVF_RETRY_MSB:`OUVF_RETRY_LSB];
	assign dcode     = action_reg[`OUVF_DELAY_MSB:`OUVF_DELAY_LSB];

	// Two-flop synchroniser on the fault flag
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fault_meta <= 1'b0;
			fault_s    <= 1'b0;
		end
		else
		begin
			fault_meta <= uv_fault;
			fault_s    <= fault_meta;
		end
	end

	// Action register; changes take effect on the running sequence
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			action_reg <= `OUVF_ACTION_RESET;
		else if (cfg_wr_en && cfg_addr == `OUVF_ADDR_ACTION)
			action_reg <= cfg_wdata;
	end

	// Unmapped reads answer zero
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			rdata_reg <= 8'h00;
		else if (cfg_rd_en)
			rdata_reg <= (cfg_addr == `OUVF_ADDR_ACTION) ? action_reg : 8'h00;
	end

	// Delay pair lookup
	always_comb
	begin
		target_ms = 12'h000;
		if (state_reg == ouvf_pkg::OUVF_ST_RIDE)
			target_ms = `OUVF_D1_BASE_MS << dcode;
		else
		begin
			case (dcode)
				3'h0: target_ms = `OUVF_D2_MS_0;
				3'h1: target_ms = `OUVF_D2_MS_1;
				3'h2: target_ms = `OUVF_D2_MS_2;
				3'h3: target_ms = `OUVF_D2_MS_3;
				3'h4: target_ms = `OUVF_D2_MS_4;
				3'h5: target_ms = `OUVF_D2_MS_5;
				3'h6: target_ms = `OUVF_D2_MS_6;
				default: target_ms = `OUVF_D2_MS_7;
			endcase
		end
	end

	assign timer_done = (ms_reg >= target_ms);
	assign seq_start  = (state_next != state_reg) &&
		(state_next == ouvf_pkg::OUVF_ST_RIDE ||
		 state_next == ouvf_pkg::OUVF_ST_OFF);
	// Unlimited retries never exhaust
	assign out_of_retries = (retry_lim != `OUVF_RETRY_FOREVER) &&
		(retry_reg >= retry_lim);

	// Millisecond timer; a coarse tick keeps the counters narrow
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pre_reg <= 16'h0000;
			ms_reg  <= 12'h000;
		end
		else if (seq_start)
		begin
			pre_reg <= 16'h0000;
			ms_reg  <= 12'h000;
		end
		else if (pre_reg == 16'(MS_CYCLES - 1))
		begin
			pre_reg <= 16'h0000;
			if (ms_reg != 12'hFFF)
				ms_reg <= ms_reg + 12'h001;
		end
		else
			pre_reg <= pre_reg + 16'h0001;
	end

	// Sequencer
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ouvf_pkg::OUVF_ST_RUN:
			begin
				if (fault_s)
				begin
					case (resp)
						`OUVF_RESP_RIDE: state_next = ouvf_pkg::OUVF_ST_RIDE;
						`OUVF_RESP_SHUT: state_next = out_of_retries ?
							ouvf_pkg::OUVF_ST_LATCH : ouvf_pkg::OUVF_ST_OFF;
						`OUVF_RESP_HOLD: state_next = ouvf_pkg::OUVF_ST_HOLD;
						default: state_next = ouvf_pkg::OUVF_ST_RUN;
					endcase
				end
			end
			ouvf_pkg::OUVF_ST_RIDE:
			begin
				if (!fault_s)
					state_next = ouvf_pkg::OUVF_ST_RUN;
				else if (timer_done)
					state_next = out_of_retries ?
						ouvf_pkg::OUVF_ST_LATCH : ouvf_pkg::OUVF_ST_OFF;
			end
			ouvf_pkg::OUVF_ST_OFF:
			begin
				if (timer_done)
					state_next = ouvf_pkg::OUVF_ST_RESTART;
			end
			ouvf_pkg::OUVF_ST_RESTART:
				state_next = ouvf_pkg::OUVF_ST_RUN;
			ouvf_pkg::OUVF_ST_HOLD:
			begin
				if (!fault_s)
					state_next = ouvf_pkg::OUVF_ST_RUN;
			end
			ouvf_pkg::OUVF_ST_LATCH:
				state_next = ouvf_pkg::OUVF_ST_LATCH;
			default: state_next = ouvf_pkg::OUVF_ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			state_reg <= ouvf_pkg::OUVF_ST_RUN;
		else
			state_reg <= state_next;
	end

	// Retry count survives the restart; cleared once the fault is gone
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			retry_reg <= 3'h0;
		else if (state_reg == ouvf_pkg::OUVF_ST_RUN && !fault_s)
			retry_reg <= 3'h0;
		else if (state_next == ouvf_pkg::OUVF_ST_OFF &&
			state_reg != ouvf_pkg::OUVF_ST_OFF &&
			retry_lim != `OUVF_RETRY_FOREVER)
			retry_reg <= retry_reg + 3'h1;
	end

	// Output enable and latched flag follow the next state
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_en_reg  <= 1'b1;
			latched_reg <= 1'b0;
		end
		else
		begin
			out_en_reg  <= (state_next == ouvf_pkg::OUVF_ST_RUN ||
				state_next == ouvf_pkg::OUVF_ST_RIDE ||
				state_next == ouvf_pkg::OUVF_ST_RESTART);
			latched_reg <= (state_next == ouvf_pkg::OUVF_ST_LATCH);
		end
	end

	assign cfg_rdata     = rdata_reg;
	assign out_enable    = out_en_reg;
	assign fault_latched = latched_reg;
	assign retries_used  = retry_reg;

	ignore_keeps_a: assert property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_RUN && resp == `OUVF_RESP_IGNORE
		|=> out_en_reg) else $error("output dropped while ignoring");
	ride_keeps_a: assert property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_RUN && fault_s &&
		resp == `OUVF_RESP_RIDE |=> out_en_reg && state_reg ==
		ouvf_pkg::OUVF_ST_RIDE) else $error("ride-through not entered");
	shut_now_a: assert property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_RUN && fault_s &&
		resp == `OUVF_RESP_SHUT |=> !out_en_reg)
		else $error("no immediate shutdown");
	hold_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_HOLD |=>
		(out_en_reg == !$past(fault_s)))
		else $error("hold output wrong");
	retry_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_RESTART |-> retry_reg != 3'h0 ||
		retry_lim == `OUVF_RETRY_FOREVER)
		else $error("restart without counted retry");
	exhaust_latch_a: assert property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_RIDE && fault_s && timer_done &&
		out_of_retries |=> latched_reg && !out_en_reg)
		else $error("exhausted fault not latched");
	latch_stays_a: assert property (@(posedge core_clk) disable iff (!nrst)
		latched_reg |=> latched_reg && !out_en_reg)
		else $error("latch released without reset");
	spacing_a: assert property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_OFF && !timer_done
		|=> state_reg == ouvf_pkg::OUVF_ST_OFF && !out_en_reg)
		else $error("restart before delay two");
	delay_exact_a: assert property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_RIDE && $rose(timer_done)
		|-> ms_reg == (`OUVF_D1_BASE_MS << dcode))
		else $error("delay one length wrong");
	forever_a: assert property (@(posedge core_clk) disable iff (!nrst)
		retry_lim == `OUVF_RETRY_FOREVER && !latched_reg |=> !latched_reg)
		else $error("unlimited retries latched");
	timer_restart_a: assert property (@(posedge core_clk) disable iff (!nrst)
		seq_start |=> ms_reg == 12'h000 && pre_reg == 16'h0000)
		else $error("timer not restarted");

	ride_cov_c: cover property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_RIDE ##1
		state_reg == ouvf_pkg::OUVF_ST_OFF);
	restart_cov_c: cover property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_RESTART);
	latch_cov_c: cover property (@(posedge core_clk) disable iff (!nrst)
		$rose(latched_reg));
	hold_cov_c: cover property (@(posedge core_clk) disable iff (!nrst)
		state_reg == ouvf_pkg::OUVF_ST_HOLD ##1
		state_reg == ouvf_pkg::OUVF_ST_RUN);
endmodule // ouvf_responder
`default_nettype wire

// *** rtl/ouvf_regs.svh ***
/*
 * Register map, field layout, reset value and timing constants of the
 * output undervoltage fault responder.
 * Assumes a 40 MHz core clock and an 8-bit management register port.
 */
// Overview of operation
// - Bits 7:6 pick the fault action, and code 00 ignores the fault.
// - Code 01 rides through delay one, then shuts down and retries.
// - Code 10 shuts the output down at once, then retries.
// - Code 11 holds the output off until the fault clears, then restarts.
// - Bits 5:3 give the restart count in plain binary, except code 7, which restarts without limit.
// - A fault that outlasts all restarts leaves the output off for good.
// - That latched state ends only with a reset or a power cycle.
// - Restart attempts are spaced by delay two from bits 2:0.
// - Delay code n pairs delay one of 10 ms << n with delay two 252-2604 ms.
`ifndef OUVF_REGS_SVH
`define OUVF_REGS_SVH

`define OUVF_ADDR_ACTION   8'h45
`define OUVF_ACTION_RESET  8'h00
`define OUVF_RESP_MSB      7
`define OUVF_RESP_LSB      6
`define OUVF_RETRY_MSB     5
`define OUVF_RETRY_LSB     3
`define OUVF_DELAY_MSB     2
`define OUVF_DELAY_LSB     0
`define OUVF_RESP_IGNORE   2'h0
`define OUVF_RESP_RIDE     2'h1
`define OUVF_RESP_SHUT     2'h2
`define OUVF_RESP_HOLD     2'h3
`define OUVF_RETRY_FOREVER 3'h7

`define OUVF_CLK_HZ        40000000
`define OUVF_MS_CYCLES     (`OUVF_CLK_HZ / 1000)
`define OUVF_D1_BASE_MS    12'hA
`define OUVF_D2_MS_0       12'h0FC
`define OUVF_D2_MS_1       12'h22E
`define OUVF_D2_MS_2       12'h39C
`define OUVF_D2_MS_3       12'h4EC
`define OUVF_D2_MS_4       12'h63C
`define OUVF_D2_MS_5       12'h78C
`define OUVF_D2_MS_6       12'h8DC
`define OUVF_D2_MS_7       12'hA2C

`endif

// *** rtl/ouvf_pkg.sv ***
/*
 * Types shared by the output undervoltage fault responder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package ouvf_pkg;
	typedef enum logic [5:0] {
		OUVF_ST_RUN     = 6'h01,
		OUVF_ST_RIDE    = 6'h02,
		OUVF_ST_OFF     = 6'h04,
		OUVF_ST_RESTART = 6'h08,
		OUVF_ST_HOLD    = 6'h10,
		OUVF_ST_LATCH   = 6'h20
	} ouvf_state_e;
endpackage
`default_nettype wire

// *** test/ouvf_host.sv ***
/*
 * Host model: management bus master that writes and reads the action
 * register. Assumes the block samples its strobes on rising core_clk.
 */
`default_nettype none
module ouvf_host (
	// Clock
	input  wire logic       core_clk,
	// Register port
	output logic      [7:0] cfg_addr,
	output logic            cfg_wr_en,
	output logic      [7:0] cfg_wdata,
	output logic            cfg_rd_en,
	input  wire logic [7:0] cfg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		cfg_addr = 8'h00;
		cfg_wr_en = 1'b0;
		cfg_wdata = 8'h00;
		cfg_rd_en = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #2;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr_en = 1'b1;
		@(posedge core_clk) #2;
		cfg_wr_en = 1'b0;
		// Released data must not look valid
		cfg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk) #2;
		cfg_addr = a;
		cfg_rd_en = 1'b1;
		@(posedge core_clk) #2;
		cfg_rd_en = 1'b0;
		d = cfg_rdata;
	endtask
endmodule // ouvf_host
`default_nettype wire

// *** test/output_undervoltage_fault_responder_tb_top.sv ***
/*
 * Self-checking bench of the fault responder with the host model.
 * Assumes MS_CYCLES of 4, so delay one is 40 and delay two 1008 cycles.
 */
`include "ouvf_regs.svh"
`default_nettype none
module output_undervoltage_fault_responder_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       core_clk, nrst, uv_fault, cfg_wr_en, cfg_rd_en;
	logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, v;
	logic       out_enable, fault_latched;
	logic [2:0] retries_used;
	int         bad_count = 0;
	int         compares = 0;
	int         n;
	ouvf_responder #(.MS_CYCLES(4)) ouvf_responder_inst (.core_clk(core_clk),
		.nrst(nrst), .uv_fault(uv_fault), .cfg_addr(cfg_addr),
		.cfg_wr_en(cfg_wr_en), .cfg_wdata(cfg_wdata), .cfg_rd_en(cfg_rd_en),
		.cfg_rdata(cfg_rdata), .out_enable(out_enable),
		.fault_latched(fault_latched), .retries_used(retries_used));
	ouvf_host ouvf_host_inst (.core_clk(core_clk), .cfg_addr(cfg_addr),
		.cfg_wr_en(cfg_wr_en), .cfg_wdata(cfg_wdata),
		.cfg_rd_en(cfg_rd_en), .cfg_rdata(cfg_rdata));
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic stop_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic do_reset;
		nrst = 1'b0;
		uv_fault = 1'b0;
		repeat (2) @(posedge core_clk);
		#2 nrst = 1'b1;
	endtask
	task automatic fault(input logic f);
		@(posedge core_clk) #2;
		uv_fault = f;
	endtask
	// Counts cycles until out_enable reaches lvl, bounded by lim
	task automatic wait_out(input logic lvl, input int lim);
		n = 0;
		while (out_enable !== lvl && n < lim)
		begin
			@(posedge core_clk) #2;
			n++;
		end
	endtask
	task automatic t_regs;
		ouvf_host_inst.rd(`OUVF_ADDR_ACTION, v);
		chk("reset value", 8'h00, v);
		chk("enable at reset", 8'h01, {7'h00, out_enable});
		ouvf_host_inst.wr(`OUVF_ADDR_ACTION, 8'hA5);
		ouvf_host_inst.wr(8'h12, 8'hFF);
		ouvf_host_inst.rd(8'h12, v);
		chk("unmapped read", 8'h00, v);
		ouvf_host_inst.rd(`OUVF_ADDR_ACTION, v);
		chk("readback", 8'hA5, v);
	endtask
	task automatic t_ignore;
		ouvf_host_inst.wr(`OUVF_ADDR_ACTION, 8'h00);
		fault(1'b1);
		repeat (60) @(posedge core_clk);
		chk("ignore enable", 8'h01, {7'h00, out_enable});
		fault(1'b0);
	endtask
	task automatic t_ride;
		ouvf_host_inst.wr(`OUVF_ADDR_ACTION, 8'h48);
		fault(1'b1);
		wait_out(1'b0, 100);
		chk("ride delay", 8'h01, {7'h00, n >= 40 && n <= 46});
		do_reset;
	endtask
	task automatic t_shut;
		ouvf_host_inst.wr(`OUVF_ADDR_ACTION, 8'h88);
		fault(1'b1);
		wait_out(1'b0, 10);
		chk("shut at once", 8'h01, {7'h00, n <= 5});
		chk("retry count", 8'h01, {5'h00, retries_used});
		wait_out(1'b1, 1100);
		chk("restart gap", 8'h01, {7'h00, n >= 1000 && n <= 1012});
		repeat (10) @(posedge core_clk);
		chk("latched", 8'h01, {7'h00, fault_latched});
		fault(1'b0);
		repeat (50) @(posedge core_clk);
		chk("stays off", 8'h02, {6'h00, fault_latched, out_enable});
		do_reset;
		#1 chk("reset clears", 8'h01, {6'h00, fault_latched, out_enable});
		ouvf_host_inst.wr(`OUVF_ADDR_ACTION, 8'h80);
		fault(1'b1);
		repeat (10) @(posedge core_clk);
		chk("no retries", 8'h02, {6'h00, fault_latched, out_enable});
		do_reset;
	endtask
	task automatic t_hold;
		ouvf_host_inst.wr(`OUVF_ADDR_ACTION, 8'hC0);
		fault(1'b1);
		wait_out(1'b0, 10);
		chk("hold off", 8'h01, {7'h00, n <= 5});
		repeat (100) @(posedge core_clk);
		chk("held", 8'h00, {7'h00, out_enable});
		fault(1'b0);
		wait_out(1'b1, 10);
		chk("hold release", 8'h01, {7'h00, n <= 5});
	endtask
	initial
	begin
		uv_fault = 1'b0;
		do_reset;
		t_regs;
		t_ignore;
		t_ride;
		t_shut;
		t_hold;
		stop_test;
	end
	// Run needs about 1300 cycles
	initial
	begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		stop_test;
	end
endmodule // output_undervoltage_fault_responder_tb_top
`default_nettype wire
